// [tof_pkg.sv]
/*
 Constants for the T1/J1 overhead and data-link framer block: register
 indexes, field positions, reset values, framing patterns and codes.
 Assumes an APB master with 32-bit data and a framer that marks bits.
*/
package tof_pkg;
	typedef enum logic [1:0] {
		TOF_FMT_SF = 2'b00,
		TOF_FMT_ESF = 2'b01,
		TOF_FMT_DM = 2'b10,
		TOF_FMT_SLC = 2'b11
	} tof_fmt_e;

	// Register indexes; byte address is four times the index
	localparam logic [9:0] REG_ERR_FLAGS = 10'h053;
	localparam logic [9:0] REG_RX_CONC_LOW = 10'h056;
	localparam logic [9:0] REG_RX_MAINT_CONC_HIGH = 10'h057;
	localparam logic [9:0] REG_RX_SWITCH_ALARM = 10'h058;
	localparam logic [9:0] REG_CHG_IRQ_EN = 10'h05c;
	localparam logic [9:0] REG_CHG_FLAGS = 10'h05d;
	localparam logic [9:0] REG_TX_MODE = 10'h062;
	localparam logic [9:0] REG_TX_CONC_LOW = 10'h065;
	localparam logic [9:0] REG_TX_MAINT_CONC_HIGH = 10'h066;
	localparam logic [9:0] REG_TX_SWITCH_ALARM = 10'h067;

	// Field positions
	localparam int MODE_FRAME_GEN_DISABLE = 0;
	localparam int MODE_CRC_INSERT_BYPASS = 1;
	localparam int MODE_DLBYP = 2;
	localparam int IRQ_EN_DEBOUNCE = 4;
	localparam int ERR_CRC = 2;
	localparam int ERR_FBIT = 1;
	localparam int ERR_COFA = 0;

	// Reset values
	localparam logic [2:0] RST_MODE = 3'h0;
	localparam logic [4:0] RST_IRQ_EN = 5'h00;
	localparam logic [10:0] RST_CONC = 11'h000;
	localparam logic [2:0] RST_MAINT = 3'h0;
	localparam logic [3:0] RST_SWITCH = 4'h0;
	localparam logic [1:0] RST_ALARM = 2'h0;

	// Framing patterns, bit i belongs to the i-th Fs or FAS frame, counted from 0
	localparam logic [7:0] SF_FS_PAT = 8'h1c;
	localparam logic [7:0] ESF_FAS_PAT = 8'h34;
	localparam logic [15:0] SLC_SYNC_PAT = 16'h0e38;
	localparam logic SLC_FS_LAST = 1'b1;
	localparam logic [2:0] SLC_SPOIL = 3'h2;
	localparam logic [5:0] SLC_LAST_K = 6'h23;
	localparam logic [5:0] SLC_SYNC_LAST_K = 6'h0a;
	localparam logic [5:0] SLC_C_FIRST_K = 6'h0c;
	localparam logic [5:0] SLC_DATA_LAST_K = 6'h22;
	localparam logic [5:0] SLC_SPOIL_FIRST_K = 6'h17;
	localparam logic [5:0] SLC_SPOIL_LAST_K = 6'h19;
	localparam logic [5:0] SF_FS_LAST_K = 6'h05;

	// Codes and positions
	localparam logic [5:0] CRC6_POLY = 6'h03;
	localparam logic [15:0] IDLE_T1 = 16'hffff;
	localparam logic [15:0] IDLE_J1 = 16'hff7e;
	localparam logic [7:0] DM_DBIT_POS = 8'hbe;
endpackage

// [tof_framer.sv]
/*
 T1/J1 overhead framer: receive F-bit and CRC-6 checks, SLC-96 overhead
 extraction with change flags, transmit framing and overhead insertion.
 Assumes the line framer marks each bit, each F bit and multiframe start.
*/
// Chosen here: the APB slave port.
`timescale 1ns/1ns
module tof_framer
	import tof_pkg::*;
(
	input wire logic clk_sys_in, // System clock
	input wire logic rst_in, // Async reset, high
	input wire logic [11:0] paddr_in, // APB address
	input wire logic psel_in, // APB select
	input wire logic penable_in, // APB enable
	input wire logic pwrite_in, // APB write
	input wire logic [31:0] pwdata_in, // APB write data
	output logic [31:0] prdata_out, // APB read data
	output logic pready_out, // APB ready
	output logic pslverr_out, // APB error
	input wire logic [1:0] fmt_in, // Framing format
	input wire logic j1_mode_in, // J1 idle code
	input wire logic rx_bit_valid_in, // Receive bit strobe
	input wire logic rx_bit_in, // Receive bit
	input wire logic rx_fbit_in, // Bit is an F bit
	input wire logic rx_mf_start_in, // First frame of multiframe
	input wire logic rx_in_sync_in, // Receiver in sync
	input wire logic rx_fpos_valid_in, // F position found
	input wire logic [7:0] rx_fpos_in, // Found F position
	input wire logic tx_bit_valid_in, // Transmit bit strobe
	input wire logic tx_bit_in, // Transmit bit
	input wire logic tx_fbit_in, // Bit is an F bit
	input wire logic tx_mf_start_in, // First frame of multiframe
	input wire logic tx_hdlc_bit_in, // HDLC data bit
	output logic tx_bit_out, // Framed transmit bit
	output logic tx_bit_valid_out, // Framed bit strobe
	output logic irq_out // Change interrupt, high
);
	// Serial CRC-6 step
	function automatic logic [5:0] crc_step(input logic [5:0] c, input logic b);
		logic fb;
		fb = b ^ c[5];
		crc_step = {c[4:0], 1'b0} ^ (fb ? CRC6_POLY : 6'h00);
	endfunction

	logic [2:0] mode;
	logic [4:0] irq_en;
	logic [3:0] chg;
	logic [2:0] err;
	logic [10:0] rx_conc;
	logic [2:0] rx_maint;
	logic [3:0] rx_sw;
	logic [1:0] rx_alarm;
	logic [10:0] tx_conc;
	logic [2:0] tx_maint;
	logic [3:0] tx_sw;
	logic [1:0] tx_alarm;

	// APB decode
	wire [9:0] widx = paddr_in[11:2];
	wire acc = psel_in & penable_in;
	wire wr = acc & pready_out & pwrite_in;
	wire s_err = (widx == REG_ERR_FLAGS);
	wire s_rc0 = (widx == REG_RX_CONC_LOW);
	wire s_rc1 = (widx == REG_RX_MAINT_CONC_HIGH);
	wire s_rc2 = (widx == REG_RX_SWITCH_ALARM);
	wire s_ien = (widx == REG_CHG_IRQ_EN);
	wire s_chg = (widx == REG_CHG_FLAGS);
	wire s_mode = (widx == REG_TX_MODE);
	wire s_tc0 = (widx == REG_TX_CONC_LOW);
	wire s_tc1 = (widx == REG_TX_MAINT_CONC_HIGH);
	wire s_tc2 = (widx == REG_TX_SWITCH_ALARM);
	wire hit = s_err | s_rc0 | s_rc1 | s_rc2 | s_ien | s_chg | s_mode | s_tc0 | s_tc1 | s_tc2;
	wire [7:0] rd_byte = s_err ? {5'h00, err} :
		s_rc0 ? rx_conc[7:0] :
		s_rc1 ? {2'h0, rx_maint, rx_conc[10:8]} :
		s_rc2 ? {2'h0, rx_sw, rx_alarm} :
		s_ien ? {3'h0, irq_en} :
		s_chg ? {4'h0, chg} :
		s_mode ? {5'h00, mode} :
		s_tc0 ? tx_conc[7:0] :
		s_tc1 ? {2'h0, tx_maint, tx_conc[10:8]} :
		s_tc2 ? {2'h0, tx_sw, tx_alarm} : 8'h00;

	// APB answer: one wait state, then ready with data
	// Ready drops after one cycle, so a held request waits again
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pready_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end
		else
		begin
			pready_out <= acc & ~pready_out;
			prdata_out <= {24'h00_0000, rd_byte};
			pslverr_out <= acc & ~pready_out & ~hit;
		end
	end

	// Control register writes
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			mode <= RST_MODE;
			irq_en <= RST_IRQ_EN;
			tx_conc <= RST_CONC;
			tx_maint <= RST_MAINT;
			tx_sw <= RST_SWITCH;
			tx_alarm <= RST_ALARM;
		end
		else if (wr)
		begin
			if (s_mode)
				mode <= pwdata_in[2:0];
			if (s_ien)
				irq_en <= pwdata_in[4:0];
			if (s_tc0)
				tx_conc[7:0] <= pwdata_in[7:0];
			if (s_tc1)
				{tx_maint, tx_conc[10:8]} <= pwdata_in[5:0];
			if (s_tc2)
				{tx_sw, tx_alarm} <= pwdata_in[5:0];
		end
	end

	// Receive frame numbering, frames count from 1
	logic [6:0] rx_fr;
	wire rx_f = rx_bit_valid_in & rx_fbit_in;
	wire [6:0] rx_fr_n = rx_mf_start_in ? 7'd1 : rx_fr + 7'd1;
	wire [5:0] rx_half = rx_fr_n[6:1];
	wire [5:0] rx_k = rx_half - 6'd1;
	wire [2:0] rx_fas = rx_fr_n[4:2] - 3'd1;
	wire rx_odd = rx_fr_n[0];

	// Expected F bit per format
	wire sf_chk = rx_odd | (rx_k <= SF_FS_LAST_K);
	wire sf_exp = rx_odd ? ~rx_half[0] : SF_FS_PAT[rx_k[2:0]];
	wire esf_chk = (rx_fr_n[1:0] == 2'b00);
	wire esf_exp = ESF_FAS_PAT[rx_fas];
	wire slc_chk = rx_odd | (rx_k <= SLC_SYNC_LAST_K) | (rx_k == SLC_LAST_K);
	wire slc_exp = rx_odd ? ~rx_half[0] :
		(rx_k == SLC_LAST_K) ? SLC_FS_LAST : SLC_SYNC_PAT[rx_k[3:0]];
	wire f_chk = (fmt_in == TOF_FMT_ESF) ? esf_chk :
		(fmt_in == TOF_FMT_SLC) ? slc_chk : sf_chk;
	wire f_exp = (fmt_in == TOF_FMT_ESF) ? esf_exp :
		(fmt_in == TOF_FMT_SLC) ? slc_exp : sf_exp;
	wire ev_fbit = rx_f & rx_in_sync_in & f_chk & (rx_bit_in != f_exp);

	// Receive CRC-6
	logic [5:0] rx_crc_acc;
	logic [5:0] rx_crc_prev;
	logic rx_crc_ok;
	logic [5:0] rx_crc_got;
	wire rx_esf = (fmt_in == TOF_FMT_ESF);
	wire rx_sf_end = rx_f & rx_mf_start_in;
	wire ev_crc = rx_sf_end & rx_esf & rx_crc_ok & (rx_crc_got != rx_crc_prev);

	// Position change
	logic [7:0] fpos_prev;
	logic fpos_seen;
	wire ev_cofa = rx_fpos_valid_in & fpos_seen & (rx_fpos_in != fpos_prev);

	// Receive counters, CRC and position tracking
	// CRC compare counts only after one full in-sync superframe
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rx_fr <= 7'd0;
			rx_crc_acc <= 6'h00;
			rx_crc_prev <= 6'h00;
			rx_crc_ok <= 1'b0;
			rx_crc_got <= 6'h00;
			fpos_prev <= 8'h00;
			fpos_seen <= 1'b0;
		end
		else
		begin
			if (rx_f)
				rx_fr <= rx_fr_n;
			if (rx_bit_valid_in)
				rx_crc_acc <= crc_step(rx_sf_end ? 6'h00 : rx_crc_acc, rx_fbit_in | rx_bit_in);
			if (rx_sf_end)
			begin
				rx_crc_prev <= rx_crc_acc;
				rx_crc_ok <= rx_esf & rx_in_sync_in;
			end
			if (rx_f & (rx_fr_n[1:0] == 2'b10))
				rx_crc_got <= {rx_crc_got[4:0], rx_bit_in};
			if (rx_fpos_valid_in)
			begin
				fpos_prev <= rx_fpos_in;
				fpos_seen <= 1'b1;
			end
		end
	end

	// Error flags, set wins over clear
	// An event in the cycle of a clear write keeps the flag set
	wire [2:0] err_clr = (wr & s_err) ? pwdata_in[2:0] : 3'h0;
	wire [2:0] err_set = {ev_crc, ev_fbit, ev_cofa};
	wire [2:0] next_err = (err & ~err_clr) | err_set;

	// SLC-96 Fs data capture, first bit ends at the LSB
	// Capture runs in any format; only the end strobe is qualified
	logic [22:0] slc_sr;
	logic [10:0] cand_c;
	logic [2:0] cand_m;
	logic [1:0] cand_a;
	logic [3:0] cand_s;
	wire slc_data = rx_f & ~rx_odd & (rx_k >= SLC_C_FIRST_K) & (rx_k <= SLC_DATA_LAST_K);
	wire slc_end = rx_f & ~rx_odd & (rx_k == SLC_LAST_K) & (fmt_in == TOF_FMT_SLC)
		& rx_in_sync_in;
	wire [10:0] new_c = slc_sr[10:0];
	wire [2:0] new_m = slc_sr[16:14];
	wire [1:0] new_a = slc_sr[18:17];
	wire [3:0] new_s = slc_sr[22:19];
	wire deb = irq_en[IRQ_EN_DEBOUNCE];
	wire up_c = slc_end & (~deb | (new_c == cand_c));
	wire up_m = slc_end & (~deb | (new_m == cand_m));
	wire up_a = slc_end & (~deb | (new_a == cand_a));
	wire up_s = slc_end & (~deb | (new_s == cand_s));
	wire [3:0] chg_set = {up_a & (new_a != rx_alarm), up_s & (new_s != rx_sw),
		up_m & (new_m != rx_maint), up_c & (new_c != rx_conc)};
	wire [3:0] chg_clr = (wr & s_chg) ? pwdata_in[3:0] : 4'h0;
	wire [3:0] next_chg = (chg & ~chg_clr) | chg_set;

	// Overhead extraction and flag registers
	// Candidates refresh every in-sync SLC-96 multiframe, so de-bounce compares neighbours
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			slc_sr <= 23'h00_0000;
			{cand_c, cand_m, cand_a, cand_s} <= 20'h0_0000;
			rx_conc <= RST_CONC;
			rx_maint <= RST_MAINT;
			rx_alarm <= RST_ALARM;
			rx_sw <= RST_SWITCH;
			chg <= 4'h0;
			err <= 3'h0;
			irq_out <= 1'b0;
		end
		else
		begin
			if (slc_data)
				slc_sr <= {rx_bit_in, slc_sr[22:1]};
			if (slc_end)
				{cand_c, cand_m, cand_a, cand_s} <= {new_c, new_m, new_a, new_s};
			if (up_c)
				rx_conc <= new_c;
			if (up_m)
				rx_maint <= new_m;
			if (up_a)
				rx_alarm <= new_a;
			if (up_s)
				rx_sw <= new_s;
			chg <= next_chg;
			err <= next_err;
			irq_out <= |(next_chg & irq_en[3:0]);
		end
	end

	// Transmit frame numbering and bit position
	logic [6:0] tx_fr;
	logic [7:0] tx_pos;
	wire tx_f = tx_bit_valid_in & tx_fbit_in;
	wire [6:0] tx_fr_n = tx_mf_start_in ? 7'd1 : tx_fr + 7'd1;
	wire [7:0] tx_pos_n = tx_fbit_in ? 8'h00 : tx_pos + 8'h01;
	wire [5:0] tx_half = tx_fr_n[6:1];
	wire [5:0] tx_k = tx_half - 6'd1;
	wire [2:0] tx_fas = tx_fr_n[4:2] - 3'd1;
	wire tx_odd = tx_fr_n[0];
	wire gen = ~mode[MODE_FRAME_GEN_DISABLE];
	wire dl_on = gen & ~mode[MODE_DLBYP];

	// Transmit CRC-6 and data-link idle code
	logic [5:0] tx_crc_acc;
	logic [5:0] tx_crc_out;
	logic [3:0] tx_dl_idx;
	wire tx_sf_end = tx_f & tx_mf_start_in;
	wire [15:0] idle = j1_mode_in ? IDLE_J1 : IDLE_T1;

	// SLC-96 Fs word, index k, C1 at 12 and C11 at 22
	wire [35:0] slc_word = {SLC_FS_LAST, tx_sw, tx_alarm, tx_maint, SLC_SPOIL, tx_conc,
		SLC_SYNC_PAT[11:0]};
	wire tx_slc_dat = (tx_k >= SLC_C_FIRST_K) & (tx_k <= SLC_DATA_LAST_K)
		& ~((tx_k >= SLC_SPOIL_FIRST_K) & (tx_k <= SLC_SPOIL_LAST_K));
	wire slc_fs = (tx_slc_dat & ~dl_on) ? tx_bit_in : slc_word[tx_k];

	// Transmit F bit choice per format
	// Generation disabled passes the incoming F bit untouched
	wire sf_f = tx_odd ? ~tx_half[0] :
		(tx_k <= SF_FS_LAST_K) ? SF_FS_PAT[tx_k[2:0]] : tx_bit_in;
	wire esf_f = (tx_fr_n[1:0] == 2'b00) ? ESF_FAS_PAT[tx_fas] :
		(tx_fr_n[1:0] == 2'b10) ? (mode[MODE_CRC_INSERT_BYPASS] ? tx_bit_in : tx_crc_out[5]) :
		(dl_on ? idle[~tx_dl_idx] : tx_bit_in);
	wire slc_f = tx_odd ? ~tx_half[0] : slc_fs;
	wire f_out = (fmt_in == TOF_FMT_ESF) ? esf_f :
		(fmt_in == TOF_FMT_SLC) ? slc_f : sf_f;
	wire dm_d = (fmt_in == TOF_FMT_DM) & ~tx_fbit_in & (tx_pos_n == DM_DBIT_POS) & dl_on;
	wire next_tx = (tx_fbit_in & gen) ? f_out :
		dm_d ? tx_hdlc_bit_in : tx_bit_in;

	// Transmit counters, CRC and output
	// Data-link index runs on across superframes, as the idle code does
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			tx_fr <= 7'd0;
			tx_pos <= 8'h00;
			tx_crc_acc <= 6'h00;
			tx_crc_out <= 6'h00;
			tx_dl_idx <= 4'h0;
			tx_bit_out <= 1'b0;
			tx_bit_valid_out <= 1'b0;
		end
		else
		begin
			tx_bit_valid_out <= tx_bit_valid_in;
			if (tx_bit_valid_in)
			begin
				tx_pos <= tx_pos_n;
				tx_bit_out <= next_tx;
				tx_crc_acc <= crc_step(tx_sf_end ? 6'h00 : tx_crc_acc, tx_fbit_in | tx_bit_in);
			end
			if (tx_f)
				tx_fr <= tx_fr_n;
			if (tx_sf_end)
				tx_crc_out <= tx_crc_acc;
			else if (tx_f & (tx_fr_n[1:0] == 2'b10))
				tx_crc_out <= {tx_crc_out[4:0], 1'b0};
			if (tx_f & tx_odd & (fmt_in == TOF_FMT_ESF))
				tx_dl_idx <= tx_dl_idx + 4'h1;
		end
	end
endmodule

// [tof_framer_sva.sv]
/*
 Checker for tof_framer: APB timing, interrupt causes, transmit path.
 Assumes it is bound to tof_framer and sees only its ports.
*/
`timescale 1ns/1ns
module tof_framer_sva
	import tof_pkg::*;
(
	input wire logic clk_sys_in, // System clock
	input wire logic rst_in, // Async reset
	input wire logic psel_in, // APB select
	input wire logic penable_in, // APB enable
	input wire logic pwrite_in, // APB write
	input wire logic [31:0] prdata_out, // APB read data
	input wire logic pready_out, // APB ready
	input wire logic pslverr_out, // APB error
	input wire logic [1:0] fmt_in, // Framing format
	input wire logic rx_bit_valid_in, // Receive strobe
	input wire logic tx_bit_valid_in, // Transmit strobe
	input wire logic tx_bit_in, // Transmit bit
	input wire logic tx_fbit_in, // Transmit F mark
	input wire logic tx_bit_out, // Framed bit
	input wire logic tx_bit_valid_out, // Framed strobe
	input wire logic irq_out // Interrupt
);
	// All checks on the system clock
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);

	// Register access handshake
	ready_wait_a:
	assert property (psel_in && !penable_in |=> !pready_out ##1 pready_out)
	else $error("ready not after one wait state");
	ready_once_a:
	assert property (pready_out |=> !pready_out)
	else $error("ready longer than one cycle");
	err_ready_a:
	assert property (pslverr_out |-> pready_out)
	else $error("error without ready");
	rdata_zero_a:
	assert property (pready_out |-> prdata_out[31:8] == 24'h0)
	else $error("reserved read bits not zero");

	// Interrupt moves only for a cause
	irq_rise_a:
	assert property ($rose(irq_out) |-> $past(pwrite_in && pready_out, 2) ||
		$past(rx_bit_valid_in))
	else $error("interrupt rose without cause");
	irq_fall_a:
	assert property ($fell(irq_out) |-> $past(pwrite_in && pready_out) ||
		$past(pwrite_in && pready_out, 2))
	else $error("interrupt fell without write");

	// Transmit path latency and data pass
	tx_strobe_a:
	assert property (tx_bit_valid_in |=> tx_bit_valid_out)
	else $error("framed strobe missing");
	tx_pass_a:
	assert property (tx_bit_valid_in && !tx_fbit_in && fmt_in != TOF_FMT_DM
		|=> tx_bit_out == $past(tx_bit_in))
	else $error("data bit altered");
endmodule

bind tof_framer tof_framer_sva tof_framer_sva_i (.clk_sys_in, .rst_in, .psel_in,
	.penable_in, .pwrite_in, .prdata_out, .pready_out, .pslverr_out, .fmt_in,
	.rx_bit_valid_in, .tx_bit_valid_in, .tx_bit_in, .tx_fbit_in, .tx_bit_out,
	.tx_bit_valid_out, .irq_out);

// [tof_line_model.sv]
/*
 Line model: sends SF, ESF or SLC-96 F-bit streams, records framed F bits.
 Assumes both streams share its strobe and one system clock.
*/
`timescale 1ns/1ns
module tof_line_model
	import tof_pkg::*;
(
	input wire logic clk_in, // System clock
	input wire logic tx_bit_in, // Framed bit from block
	input wire logic tx_valid_in, // Framed strobe from block
	output logic bit_valid_out, // Bit strobe
	output logic bit_out, // Bit value
	output logic fbit_out, // F bit mark
	output logic mf_start_out // Multiframe start
);
	logic [71:0] txf;
	logic f_d;

	initial {bit_valid_out, bit_out, fbit_out, mf_start_out} = 4'h0;

	// F bit of frame k, SLC fields c, m, s, a
	function automatic logic fexp(input logic slc, input int k, input logic [10:0] c,
		input logic [2:0] m, input logic [3:0] s, input logic [1:0] a);
		int j;
		j = k / 2;
		if (k % 2) return (k % 4) == 1;
		if (!slc) return SF_FS_PAT[j - 1];
		if (j < 13) return SLC_SYNC_PAT[j - 1];
		if (j < 24) return c[j - 13];
		if (j < 27) return j == 25;
		if (j < 30) return m[j - 27];
		if (j < 32) return a[j - 30];
		if (j < 36) return s[j - 32];
		return SLC_FS_LAST;
	endfunction

	// One multiframe; frame bad carries an inverted F bit
	task automatic send_mf(input logic slc, input int bad, input logic [10:0] c,
		input logic [2:0] m, input logic [3:0] s, input logic [1:0] a);
		logic f;
		for (int k = 1; k <= (slc ? 72 : 12); k++)
		begin
			f = fexp(slc, k, c, m, s, a) ^ (k == bad);
			bit_valid_out <= 1'b1;
			bit_out <= f;
			fbit_out <= 1'b1;
			mf_start_out <= (k == 1);
			@(posedge clk_in);
			bit_valid_out <= 1'b0;
			bit_out <= ~f; // Idle line never keeps the value
			fbit_out <= 1'b0;
			mf_start_out <= 1'b0;
			@(posedge clk_in);
			bit_valid_out <= 1'b1;
			bit_out <= f;
			@(posedge clk_in);
			bit_valid_out <= 1'b0;
			bit_out <= ~f;
			@(posedge clk_in);
		end
		repeat (4) @(posedge clk_in);
	endtask

	// ESF F bit of frame k: data link dl, CRC sent MSB first
	function automatic logic esf_f(input int k, input logic [5:0] crc, input logic dl);
		if (k % 2) return dl;
		if (k % 4 == 0) return ESF_FAS_PAT[k / 4 - 1];
		return crc[5 - (k - 2) / 4];
	endfunction

	// One ESF superframe, DL and data bits 0; frame bad inverted
	task automatic send_esf(input logic [5:0] crc, input int bad);
		logic f;
		for (int k = 1; k <= 24; k++)
		begin
			f = esf_f(k, crc, 1'b0) ^ (k == bad);
			bit_valid_out <= 1'b1;
			bit_out <= f;
			fbit_out <= 1'b1;
			mf_start_out <= (k == 1);
			@(posedge clk_in);
			bit_valid_out <= 1'b0;
			bit_out <= ~f;
			fbit_out <= 1'b0;
			mf_start_out <= 1'b0;
			@(posedge clk_in);
			bit_valid_out <= 1'b1;
			bit_out <= 1'b0;
			@(posedge clk_in);
			bit_valid_out <= 1'b0;
			bit_out <= 1'b1;
			@(posedge clk_in);
		end
		repeat (4) @(posedge clk_in);
	endtask

	// Keep the last 72 framed F bits, oldest at bit 0
	always @(posedge clk_in)
	begin
		f_d <= bit_valid_out && fbit_out;
		if (tx_valid_in && f_d)
			txf <= {tx_bit_in, txf[71:1]};
	end
endmodule

// [tof_tb.sv]
/*
 Testbench for tof_framer: registers, receive checks, overhead, transmit.
 Assumes tof_line_model drives both bit streams.
*/
`timescale 1ns/1ns
module testbench
	import tof_pkg::*;
;
	logic clk_sys_in, rst_in, psel, penable, pwrite, j1, in_sync, fpos_v, rde;
	logic pready, pslverr, txb, txv, irq, bv, b, fb, mf;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [1:0] fmt;
	logic [7:0] fpos;
	int bad_count, n_checks;

	tof_framer tof_framer_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .paddr_in(paddr),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .fmt_in(fmt),
		.j1_mode_in(j1), .rx_bit_valid_in(bv), .rx_bit_in(b), .rx_fbit_in(fb),
		.rx_mf_start_in(mf), .rx_in_sync_in(in_sync), .rx_fpos_valid_in(fpos_v),
		.rx_fpos_in(fpos), .tx_bit_valid_in(bv), .tx_bit_in(b), .tx_fbit_in(fb),
		.tx_mf_start_in(mf), .tx_hdlc_bit_in(1'b0), .tx_bit_out(txb),
		.tx_bit_valid_out(txv), .irq_out(irq));
	tof_line_model tof_line_model_i (.clk_in(clk_sys_in), .tx_bit_in(txb), .tx_valid_in(txv),
		.bit_valid_out(bv), .bit_out(b), .fbit_out(fb), .mf_start_out(mf));

	// System clock
	initial
	begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer, entered just after an edge
	task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk_sys_in);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys_in);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rdv = prdata;
		rde = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys_in);
		if (n >= 16)
		begin
			bad_count++;
			test_done();
		end
	endtask

	task automatic rd(input logic [9:0] ix, input logic [31:0] exp);
		apb(1'b0, ix, 8'h00);
		chk({rde, rdv[30:0]}, exp);
	endtask

	task automatic irq_is(input logic x);
		@(posedge clk_sys_in);
		chk({31'h0, irq}, {31'h0, x});
	endtask

	task automatic t_regs();
		rd(REG_RX_SWITCH_ALARM, 32'h0);
		rd(REG_CHG_FLAGS, 32'h0);
		apb(1'b1, REG_TX_MODE, 8'hff);
		rd(REG_TX_MODE, 32'h7);
		apb(1'b1, REG_RX_CONC_LOW, 8'hff);
		rd(REG_RX_CONC_LOW, 32'h0);
		rd(10'h3ff, 32'h80000000);
		apb(1'b1, REG_TX_MODE, 8'h00);
	endtask

	task automatic t_sf();
		tof_line_model_i.send_mf(1'b0, 0, 11'h0, 3'h0, 4'h0, 2'h0);
		rd(REG_ERR_FLAGS, 32'h0);
		tof_line_model_i.send_mf(1'b0, 6, 11'h0, 3'h0, 4'h0, 2'h0);
		rd(REG_ERR_FLAGS, 32'h2);
		apb(1'b1, REG_ERR_FLAGS, 8'h02);
		rd(REG_ERR_FLAGS, 32'h0);
		fmt <= TOF_FMT_DM;
		tof_line_model_i.send_mf(1'b0, 3, 11'h0, 3'h0, 4'h0, 2'h0);
		rd(REG_ERR_FLAGS, 32'h2);
		apb(1'b1, REG_ERR_FLAGS, 8'h02);
	endtask

	task automatic t_cofa();
		logic [7:0] p[3] = '{8'h10, 8'h10, 8'h20};
		for (int i = 0; i < 3; i++)
		begin
			fpos_v <= 1'b1;
			fpos <= p[i];
			@(posedge clk_sys_in);
			fpos_v <= 1'b0;
			@(posedge clk_sys_in);
			rd(REG_ERR_FLAGS, {31'h0, i == 2});
		end
		apb(1'b1, REG_ERR_FLAGS, 8'h01);
	endtask

	task automatic t_slc();
		fmt <= TOF_FMT_SLC;
		apb(1'b1, REG_CHG_IRQ_EN, 8'h0b);
		tof_line_model_i.send_mf(1'b1, 0, 11'h5a3, 3'h5, 4'h9, 2'h2);
		rd(REG_RX_CONC_LOW, 32'ha3);
		rd(REG_RX_MAINT_CONC_HIGH, 32'h2d);
		rd(REG_RX_SWITCH_ALARM, 32'h26);
		rd(REG_CHG_FLAGS, 32'hf);
		irq_is(1'b1);
		apb(1'b1, REG_CHG_FLAGS, 8'h0b);
		irq_is(1'b0);
		rd(REG_CHG_FLAGS, 32'h4);
		apb(1'b1, REG_CHG_IRQ_EN, 8'h04);
		irq_is(1'b1);
		apb(1'b1, REG_CHG_FLAGS, 8'h04);
		irq_is(1'b0);
	endtask

	task automatic t_deb();
		apb(1'b1, REG_CHG_IRQ_EN, 8'h10);
		tof_line_model_i.send_mf(1'b1, 24, 11'h111, 3'h5, 4'h9, 2'h2);
		rd(REG_RX_CONC_LOW, 32'ha3);
		rd(REG_ERR_FLAGS, 32'h0);
		tof_line_model_i.send_mf(1'b1, 22, 11'h111, 3'h5, 4'h9, 2'h2);
		rd(REG_RX_CONC_LOW, 32'h11);
		rd(REG_CHG_FLAGS, 32'h1);
		rd(REG_ERR_FLAGS, 32'h2);
		in_sync <= 1'b0;
		tof_line_model_i.send_mf(1'b1, 0, 11'h222, 3'h2, 4'h2, 2'h1);
		tof_line_model_i.send_mf(1'b1, 0, 11'h222, 3'h2, 4'h2, 2'h1);
		rd(REG_RX_CONC_LOW, 32'h11);
		in_sync <= 1'b1;
	endtask

	// Modes 0, 1 and 4: inserted, disabled, bypassed
	task automatic t_tx();
		logic [19:0] fl;
		apb(1'b1, REG_TX_CONC_LOW, 8'h6d);
		apb(1'b1, REG_TX_MAINT_CONC_HIGH, 8'h35);
		apb(1'b1, REG_TX_SWITCH_ALARM, 8'h1d);
		for (int md = 0; md < 3; md++)
		begin
			apb(1'b1, REG_TX_MODE, 8'(md * md));
			fl = md ? 20'h0 : {11'h56d, 3'h6, 4'h7, 2'h1};
			tof_line_model_i.send_mf(1'b1, 0, 11'h0, 3'h0, 4'h0, 2'h0);
			for (int k = 1; k <= 72; k++)
				chk(tof_line_model_i.txf[k - 1], tof_line_model_i.fexp(1'b1, k, fl[19:9],
					fl[8:6], fl[5:2], fl[1:0]));
		end
	endtask

	// CRC-6 of one model superframe: F bits count as 1, data bits 0
	function automatic logic [5:0] crc_ref();
		logic [5:0] c;
		c = 6'h00;
		for (int i = 0; i < 48; i++)
			c = {c[4:0], 1'b0} ^ ((c[5] ^ (i % 2 == 0)) ? CRC6_POLY : 6'h00);
		return c;
	endfunction

	// ESF: receive FAS and CRC checks, transmit CRC and idle insertion
	task automatic t_esf();
		logic [5:0] k6;
		k6 = crc_ref();
		fmt <= TOF_FMT_ESF;
		apb(1'b1, REG_TX_MODE, 8'h00);
		tof_line_model_i.send_esf(6'h00, 0);
		tof_line_model_i.send_esf(k6, 0);
		apb(1'b1, REG_ERR_FLAGS, 8'h07);
		tof_line_model_i.send_esf(~k6, 4);
		rd(REG_ERR_FLAGS, 32'h2);
		for (int k = 1; k <= 24; k++)
			chk(tof_line_model_i.txf[47 + k], tof_line_model_i.esf_f(k, k6, 1'b1));
		apb(1'b1, REG_ERR_FLAGS, 8'h02);
		tof_line_model_i.send_esf(k6, 0);
		rd(REG_ERR_FLAGS, 32'h4);
	endtask

	initial
	begin
		rst_in = 1'b1;
		{psel, penable, pwrite, j1, fpos_v} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		fmt = TOF_FMT_SF;
		fpos = 8'h0;
		in_sync = 1'b1;
		bad_count = 0;
		n_checks = 0;
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		t_regs();
		t_sf();
		t_cofa();
		t_slc();
		t_deb();
		t_tx();
		t_esf();
		test_done();
	end
endmodule
